// ### include/odf_pkg.sv
// shared constants for the octal driver fault and control block
package odf_pkg;
  // frame geometry
  localparam int FRAME_BITS = 16;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  // command field positions
  localparam int CMD_ON_LSB = 0;
  localparam int CMD_DIAG_LSB = 8;
  // response field positions
  localparam int RSP_TW_BIT = 0;
  localparam int RSP_FAULT_LSB = 1;
  localparam int RSP_IN_LSB = 9;
  localparam int RSP_SF_BIT = 15;
  // first channel with a parallel drive input
  localparam int PAR_CH_LSB = 4;
  // values after reset
  localparam logic [15:0] CMD_RESET = 16'h0000;
  localparam logic [15:0] SH_RESET = 16'h0000;
  localparam logic [7:0] DRV_RESET = 8'h00;
  localparam logic [3:0] PAIR_RESET = 4'h0;
  localparam logic [3:0] IN_RESET = 4'h0;
  // fault filter time and its cycle count at the system clock
  localparam int FILTER_TIME_US = 100;
  localparam int SYS_CLK_MHZ = 250;
  localparam logic [15:0] FILTER_CYCLES = 16'(FILTER_TIME_US * SYS_CLK_MHZ);
  localparam logic [15:0] FILT_ZERO = 16'h0000;
  localparam logic [15:0] FILT_ONE = 16'h0001;
  // serial port state
  typedef enum logic [0:0] {
    SPI_IDLE = 1'b0,
    SPI_ARMED = 1'b1
  } odf_spi_st_t;
endpackage

// ### logic/odf_fault_filter.sv
// persistence filter: reports a condition only after it held for the full count
`timescale 1ns/1ps
module odf_fault_filter
  import odf_pkg::*;
#(
  parameter logic [15:0] LIMIT = FILTER_CYCLES
)
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // condition in, filtered out
  input wire logic i_raw,
  output logic o_det
);
  logic [15:0] cnt_q; // cycles the condition has held
  logic [15:0] cnt_d;
  logic det_q;
  logic det_d;

  // any gap restarts the window, so pwm shorter than the window never reports
  assign cnt_d = !i_raw ? FILT_ZERO : ((cnt_q == LIMIT) ? cnt_q : cnt_q + FILT_ONE);
  assign det_d = i_raw && (cnt_q >= LIMIT - FILT_ONE);
  assign o_det = det_q;

  // counter and detect flag
  // RQ5: continuous hold required
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      cnt_q <= FILT_ZERO;
      det_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      det_q <= det_d;
    end
  end

  property p_filt_full;
    @(posedge i_sys_clk) disable iff (i_rst)
    $rose(det_q) |-> ($past(cnt_q) == LIMIT - FILT_ONE) && $past(i_raw);
  endproperty
  a_filt_full: assert property (p_filt_full) // RQ5
    else $error("filter fired before full window");
endmodule // odf_fault_filter

// ### logic/odf_core.sv
// octal driver control: serial frame check, drive merge, fault latches, resets
// Behaviour
// RQ1: accept frame only if bits are multiple of 16
// RQ2: chip select fall arms counter, count clock rises
// RQ3: master keeps clock low at select release
// RQ4: channels 5-8 on is serial bit OR input
// RQ5: over-current and open-load need 100 us persistence
// RQ6: eight driver timers plus dedicated warning, shutdown, supply
// RQ7: open-load checked only off with diag bit set
// RQ8: open-load diagnostics paused on supply fault, disable
// RQ9: over-current latches driver off until cleared frame
// RQ10: four pair sensors, shutdown switches off both
// RQ11: warning sets bit 0, outputs stay on
// RQ12: shutdown latched in pair status, any path
// RQ13: shutdown clears when cool and pair disabled
// RQ14: select fall puts warning on serial out
// RQ15: logic supply loss clears all and turns off
// RQ16: load supply fault: off, latch bit 15
// RQ17: port stays alive, channels resume on recovery
// RQ18: bit 15 cleared by valid frame, supply good
// RQ19: latches clear same way; enable cycle, power-on
// RQ20: enable low resets logic, outputs off, standby
// RQ21: bits 0-7 drive on, 8-15 diag enable
// RQ22: response layout: warning, faults, inputs, supply fail
// RQ23: sixteen bit frames, least significant first
// RQ24: status bit set by open, over-current, overtemp
// RQ25: response is select-fall snapshot; chain delay 16
`timescale 1ns/1ps
module odf_core
  import odf_pkg::*;
#(
  parameter logic [15:0] FILT_CYC = FILTER_CYCLES
)
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // serial port pins
  input wire logic i_chip_select_low_n,
  input wire logic i_spi_clk,
  input wire logic i_spi_mosi,
  output logic o_spi_miso,
  output logic o_spi_miso_oe,
  // parallel drive inputs for channels 5 to 8
  input wire logic [3:0] i_parallel_drive_inputs,
  // device enable and supply monitors, high means good
  input wire logic i_enable,
  input wire logic i_logic_supply_ok,
  input wire logic i_load_supply_ok,
  // analog comparator results
  input wire logic [7:0] i_overcurrent_raw,
  input wire logic [7:0] i_open_load_raw,
  input wire logic [3:0] i_thermal_warn_raw,
  input wire logic [3:0] i_thermal_shut_raw,
  // driver and diagnostic controls
  output logic [7:0] o_driver_on,
  output logic [7:0] o_diag_enable,
  output logic o_standby,
  output logic o_frame_valid
);
  // widen a per-pair vector to both channels of each pair
  function automatic logic [7:0] pair2ch(input logic [3:0] p);
    pair2ch = {p[3], p[3], p[2], p[2], p[1], p[1], p[0], p[0]};
  endfunction

  // synchroniser stages; stage 0 is read only by stage 1
  logic [2:0] sclk_sq;
  logic [2:0] cs_sq;
  logic [1:0] mosi_sq;
  logic [30:0] pin_a_q;
  logic [30:0] pin_b_q;
  logic [30:0] pin_raw;

  // synchronised pins
  logic [3:0] par_s;
  logic en_s;
  logic vcc_s;
  logic vs_s;
  logic [7:0] oc_raw_s;
  logic [7:0] ol_raw_s;
  logic [3:0] tw_raw_s;
  logic [3:0] tsd_raw_s;

  // internal reset and edges
  logic rst;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;

  // serial port state
  odf_spi_st_t st_q;
  logic [CNT_W-1:0] cnt_q; // bits modulo 16
  logic any_q; // at least one bit clocked
  logic [15:0] sh_q; // snapshot out, received word in
  logic miso_q;
  logic cmd_load; // valid frame ends this cycle

  // command and fault state
  logic [15:0] cmd_q;
  logic [7:0] oc_q;
  logic [3:0] tsd_q;
  logic sf_q;
  logic [3:0] in_q;
  logic [7:0] drv_q;
  logic [7:0] diag_q;
  logic standby_q;
  logic fv_q;

  // filtered conditions
  logic [7:0] drv_filt;
  logic [7:0] drv_filt_in;
  logic [3:0] tsd_f;
  logic tw_f;
  logic load_bad;

  // next values and decode
  logic [7:0] want;
  logic [7:0] on_d;
  logic [7:0] diag_d;
  logic [7:0] oc_evt;
  logic [7:0] ol_det;
  logic [7:0] oc_clr;
  logic [7:0] ch_off;
  logic [3:0] tsd_clr;
  logic [7:0] oc_d;
  logic [3:0] tsd_d;
  logic sf_d;
  logic evt_any;
  logic [3:0] in_d;
  logic [7:0] fault_bits;
  logic [15:0] status_w;

  // pin bundle for the two flip-flop crossing
  assign pin_raw = {i_parallel_drive_inputs, i_enable, i_logic_supply_ok, i_load_supply_ok,
                    i_overcurrent_raw, i_open_load_raw, i_thermal_warn_raw, i_thermal_shut_raw};
  assign {par_s, en_s, vcc_s, vs_s, oc_raw_s, ol_raw_s, tw_raw_s, tsd_raw_s} = pin_b_q;

  // RQ15: logic supply loss resets all but the synchronisers and standby
  // RQ20: enable low resets all but the synchronisers and standby
  // RQ19: enable cycle clears latches
  assign rst = i_reset | ~en_s | ~vcc_s;

  // edges are taken between the second and third stage
  assign sclk_rise = sclk_sq[1] & ~sclk_sq[2];
  assign sclk_fall = ~sclk_sq[1] & sclk_sq[2];
  assign cs_fall = ~cs_sq[1] & cs_sq[2];
  assign cs_rise = cs_sq[1] & ~cs_sq[2];

  // synchronisers, reset only by the system reset
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      sclk_sq <= 3'b000;
      cs_sq <= 3'b111;
      mosi_sq <= 2'b00;
      pin_a_q <= 31'h0000_0000;
      pin_b_q <= 31'h0000_0000;
    end
    else
    begin
      sclk_sq <= {sclk_sq[1:0], i_spi_clk};
      cs_sq <= {cs_sq[1:0], i_chip_select_low_n};
      mosi_sq <= {mosi_sq[0], i_spi_mosi};
      pin_a_q <= pin_raw;
      pin_b_q <= pin_a_q;
    end
  end

  // RQ1: length must be whole words
  // RQ3: clock high at release voids frame
  assign cmd_load = (st_q == SPI_ARMED) & cs_rise & (cnt_q == CNT_ZERO) & any_q & ~sclk_sq[1];

  // serial port: snapshot at select fall, shift lsb first
  // RQ17: port runs through load supply faults
  always_ff @(posedge i_sys_clk)
  begin
    if (rst)
    begin
      st_q <= SPI_IDLE;
      cnt_q <= CNT_ZERO;
      any_q <= 1'b0;
      sh_q <= SH_RESET;
      miso_q <= 1'b0;
    end
    // RQ2: select fall arms counter
    // RQ14: warning shown at select fall
    // RQ25: response snapshot taken here
    else if (cs_fall)
    begin
      st_q <= SPI_ARMED;
      cnt_q <= CNT_ZERO;
      any_q <= 1'b0;
      sh_q <= status_w;
      miso_q <= status_w[RSP_TW_BIT];
    end
    else if (st_q == SPI_ARMED)
    begin
      if (cs_rise)
      begin
        st_q <= SPI_IDLE;
      end
      // RQ23: lsb first, in and out
      // RQ2: count each clock rise
      else if (sclk_rise)
      begin
        sh_q <= {mosi_sq[1], sh_q[15:1]};
        cnt_q <= cnt_q + CNT_ONE;
        any_q <= 1'b1;
      end
      // RQ25: input reaches output 16 clocks later
      else if (sclk_fall)
      begin
        miso_q <= sh_q[0];
      end
    end
  end

  // per-driver timer shared by over-current (on) and open-load (off)
  // RQ6: one shared timer per driver
  // RQ7: open-load only off with diag
  assign drv_filt_in = (drv_q & oc_raw_s) | (~drv_q & diag_q & ol_raw_s);

  // RQ6: driver, shutdown, warning, supply timers
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_drv
      odf_fault_filter #(.LIMIT(FILT_CYC)) u_filt (
        .i_sys_clk(i_sys_clk), .i_rst(rst), .i_raw(drv_filt_in[gi]), .o_det(drv_filt[gi]));
    end
    for (gi = 0; gi < 4; gi++)
    begin : g_tsd
      odf_fault_filter #(.LIMIT(FILT_CYC)) u_filt (
        .i_sys_clk(i_sys_clk), .i_rst(rst), .i_raw(tsd_raw_s[gi]), .o_det(tsd_f[gi]));
    end
  endgenerate
  odf_fault_filter #(.LIMIT(FILT_CYC)) u_tw (
    .i_sys_clk(i_sys_clk), .i_rst(rst), .i_raw(|tw_raw_s), .o_det(tw_f));
  odf_fault_filter #(.LIMIT(FILT_CYC)) u_vs (
    .i_sys_clk(i_sys_clk), .i_rst(rst), .i_raw(~vs_s), .o_det(load_bad));

  // RQ4: parallel inputs ORed in
  // RQ21: low byte drives, high byte diag
  assign want = cmd_q[CMD_ON_LSB +: 8] | {par_s, 4'h0};
  // RQ9: latched over-current blocks driver
  // RQ10: pair shutdown blocks both drivers
  // RQ11: warning alone never blocks
  // RQ16: supply fault turns all off
  assign on_d = want & ~oc_q & ~pair2ch(tsd_q | tsd_f) & {8{~load_bad}};
  // RQ8: diagnostics paused on supply fault
  assign diag_d = ~on_d & cmd_q[CMD_DIAG_LSB +: 8] & {8{~load_bad}};

  // fault events and clears; a set in the clearing cycle wins
  assign oc_evt = drv_filt & drv_q;
  assign ol_det = drv_filt & ~drv_q & diag_q;
  assign ch_off = ~sh_q[CMD_ON_LSB +: 8];
  // RQ9: clear needs that driver disabled
  assign oc_clr = {8{cmd_load}} & ch_off;
  assign oc_d = oc_evt | (oc_q & ~oc_clr);
  // RQ13: clear when cool and pair off
  assign tsd_clr = {4{cmd_load}} & ~tsd_f &
                   {ch_off[7] & ch_off[6], ch_off[5] & ch_off[4],
                    ch_off[3] & ch_off[2], ch_off[1] & ch_off[0]};
  // RQ12: latched whatever path drove it
  assign tsd_d = tsd_f | (tsd_q & ~tsd_clr);
  // RQ18: any valid frame clears, supply good
  assign sf_d = load_bad | (sf_q & ~cmd_load);

  // input states mirror live, freeze at over-current or shutdown
  assign evt_any = (|oc_evt) | (|(tsd_f & ~tsd_q));
  assign in_d = (((|oc_q) | (|tsd_q)) & ~evt_any) ? in_q : par_s;

  // RQ24: open, over-current, overtemp per driver
  assign fault_bits = oc_q | pair2ch(tsd_q) | ol_det;
  // RQ22: response word layout
  assign status_w = {sf_q, 2'b00, in_q, fault_bits, tw_f};

  // command and latched faults
  // RQ15: command and status cleared
  always_ff @(posedge i_sys_clk)
  begin
    if (rst)
    begin
      cmd_q <= CMD_RESET;
      oc_q <= DRV_RESET;
      tsd_q <= PAIR_RESET;
      sf_q <= 1'b0;
      in_q <= IN_RESET;
    end
    else
    begin
      // RQ1: only valid frames load
      // RQ16: command kept through supply fault
      cmd_q <= cmd_load ? sh_q : cmd_q;
      oc_q <= oc_d;
      tsd_q <= tsd_d;
      sf_q <= sf_d;
      in_q <= in_d;
    end
  end

  // driver outputs; channels resume from cmd_q once supply is back
  // RQ17: resume commanded state
  always_ff @(posedge i_sys_clk)
  begin
    if (rst)
    begin
      drv_q <= DRV_RESET;
      diag_q <= DRV_RESET;
      fv_q <= 1'b0;
    end
    else
    begin
      drv_q <= on_d;
      diag_q <= diag_d;
      fv_q <= cmd_load;
    end
  end

  // standby follows enable; only the system reset forces it
  // RQ20: low enable means standby
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      standby_q <= 1'b1;
    end
    else
    begin
      standby_q <= ~en_s;
    end
  end

  assign o_spi_miso = miso_q;
  assign o_spi_miso_oe = st_q;
  assign o_driver_on = drv_q;
  assign o_diag_enable = diag_q;
  assign o_standby = standby_q;
  assign o_frame_valid = fv_q;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (rst);

  // checker tally of clock rises, kept apart from the port counter
  // it wraps 16 to 1, so any nonzero multiple of 16 reads as one full word
  logic [4:0] rise_tally_q;
  always_ff @(posedge i_sys_clk)
  begin
    if (rst || cs_fall)
    begin
      rise_tally_q <= 5'h00;
    end
    else if ((st_q == SPI_ARMED) && sclk_rise && !cs_rise)
    begin
      rise_tally_q <= (rise_tally_q == 5'(FRAME_BITS)) ? 5'h01 : rise_tally_q + 5'h01;
    end
  end

  sequence s_frame_done;
    cmd_load ##1 1'b1;
  endsequence
  sequence s_oc_hit;
    (oc_evt != DRV_RESET) ##1 1'b1;
  endsequence

  property p_frame_len;
    cmd_load |-> (rise_tally_q == 5'(FRAME_BITS)) && !sclk_sq[1];
  endproperty
  a_frame_len: assert property (p_frame_len) // RQ1
    else $error("frame accepted with bad length");

  property p_arm;
    cs_fall |=> (st_q == SPI_ARMED) && (cnt_q == CNT_ZERO) && !any_q;
  endproperty
  a_arm: assert property (p_arm) // RQ2
    else $error("counter not armed at select fall");

  property p_par_or;
    $rose(drv_q[PAR_CH_LSB]) |-> $past(cmd_q[PAR_CH_LSB] | par_s[0]);
  endproperty
  a_par_or: assert property (p_par_or) // RQ4
    else $error("channel 5 on without command or input");

  property p_oc_latch;
    s_oc_hit |-> ((oc_q & $past(oc_evt)) == $past(oc_evt)) ##1 ((drv_q & oc_q) == DRV_RESET);
  endproperty
  a_oc_latch: assert property (p_oc_latch) // RQ9
    else $error("over-current not latched off");

  property p_tsd_pair;
    tsd_q[0] |=> (drv_q[1:0] == 2'b00);
  endproperty
  a_tsd_pair: assert property (p_tsd_pair) // RQ10
    else $error("pair on during shutdown");

  property p_tw_out;
    cs_fall |=> (o_spi_miso == $past(tw_f));
  endproperty
  a_tw_out: assert property (p_tw_out) // RQ14
    else $error("warning not on serial out");

  property p_vs_off;
    load_bad |=> sf_q && (drv_q == DRV_RESET);
  endproperty
  a_vs_off: assert property (p_vs_off) // RQ16
    else $error("supply fault did not stop drivers");

  property p_sf_clr;
    (cmd_load && !load_bad) |=> !sf_q;
  endproperty
  a_sf_clr: assert property (p_sf_clr) // RQ18
    else $error("supply flag survived valid frame");

  property p_cmd_hold;
    (!cmd_load) |=> $stable(cmd_q);
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) // RQ1
    else $error("command changed without valid frame");

  property p_vcc_clear;
    @(posedge i_sys_clk) disable iff (i_reset)
    (!vcc_s) |=> (cmd_q == CMD_RESET) && (drv_q == DRV_RESET) && !sf_q;
  endproperty
  a_vcc_clear: assert property (p_vcc_clear) // RQ15
    else $error("logic supply loss did not clear");

  property p_oc_clear;
    s_frame_done |-> ((oc_q & $past(oc_clr) & ~$past(oc_evt)) == DRV_RESET);
  endproperty
  a_oc_clear: assert property (p_oc_clear) // RQ9
    else $error("over-current not cleared by frame");
endmodule // odf_core

// ### tb/odf_spi_host.sv
// serial host model: drives select, clock and data, captures the response
`timescale 1ns/1ps
module odf_spi_host
(
  // host pins
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_mosi,
  // response from the device
  input wire logic i_miso
);
  // idle: select high, clock parked low between frames
  initial
  begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_mosi = 1'b0;
  end
  // open a frame, give the device time to show bit 0
  task automatic start();
    o_cs_n = 1'b0;
    #32;
  endtask
  // one bit: data set after the fall, taken by the device at the rise
  task automatic bitx(input logic b, input logic hold, output logic r);
    o_mosi = b;
    #16 o_sclk = 1'b1;
    // sampled late in the high phase, miso settles a few cycles after the fall
    #15 r = i_miso;
    #1 if (!hold) o_sclk = 1'b0;
  endtask
  task automatic word(input logic [15:0] w, input logic hold, output logic [15:0] r);
    for (int i = 0; i < 16; i++)
      bitx(w[i], hold && i == 15, r[i]);
  endtask
  // close the frame; released data line shows the inverse, not the old value
  task automatic stop();
    #16 o_cs_n = 1'b1;
    #8 o_sclk = 1'b0;
    o_mosi = ~o_mosi;
    #24;
  endtask
endmodule // odf_spi_host

// ### tb/odf_core_tb_top.sv
// self-checking bench for the octal driver control block
`timescale 1ns/1ps
module odf_core_tb_top;
  // stimulus, all set at time zero
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] par = 4'h0;
  logic en = 1'b1;
  logic vcc_ok = 1'b1;
  logic vs_ok = 1'b1;
  logic [7:0] oc = 8'h00;
  logic [7:0] ol = 8'h00;
  logic [3:0] tw = 4'h0;
  logic [3:0] ts = 4'h0;
  // host pins and device outputs
  wire logic cs_n, sclk, mosi, miso, miso_oe, stby, fv;
  wire logic [7:0] drv_on, diag;
  // diag enables above driver gates, one word to compare
  wire logic [15:0] drv = {diag, drv_on};
  logic [15:0] r, r2;
  int n_fail = 0;
  int compares = 0;
  int n_fv = 0;
  int exp_fv = 0;
  // 250 MHz system clock
  initial
  begin
    forever #2 clk = ~clk;
  end
  // short filter keeps fault scenarios brief
  odf_core #(.FILT_CYC(16'h0008)) u_dut (
    .i_sys_clk(clk), .i_reset(rst),
    .i_chip_select_low_n(cs_n), .i_spi_clk(sclk), .i_spi_mosi(mosi),
    .o_spi_miso(miso), .o_spi_miso_oe(miso_oe),
    .i_parallel_drive_inputs(par), .i_enable(en),
    .i_logic_supply_ok(vcc_ok), .i_load_supply_ok(vs_ok),
    .i_overcurrent_raw(oc), .i_open_load_raw(ol),
    .i_thermal_warn_raw(tw), .i_thermal_shut_raw(ts),
    .o_driver_on(drv_on), .o_diag_enable(diag),
    .o_standby(stby), .o_frame_valid(fv));
  odf_spi_host u_host (.o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi), .i_miso(miso));
  // count accepted-frame pulses
  always @(posedge clk)
  begin
    if (fv === 1'b1)
      n_fv++;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one valid 16-bit frame
  task automatic frm(input logic [15:0] w, output logic [15:0] rs);
    u_host.start();
    u_host.word(w, 1'b0, rs);
    u_host.stop();
    exp_fv++;
    cyc(4);
  endtask
  task automatic summarize();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // command layout, then a 15-bit frame, clock high, two-word chain
  task automatic t_frame();
    frm(16'hC03C, r);
    chk(r, 16'h0000);
    chk(drv, 16'hC03C);
    u_host.start();
    repeat (15) u_host.bitx(1'b1, 1'b0, r[0]);
    u_host.stop();
    cyc(4);
    chk(drv, 16'hC03C);
    u_host.start();
    u_host.word(16'h0000, 1'b1, r);
    u_host.stop();
    cyc(4);
    chk(drv, 16'hC03C);
    u_host.start();
    u_host.word(16'h00F0, 1'b0, r);
    u_host.word(16'h0003, 1'b0, r2);
    u_host.stop();
    exp_fv++;
    cyc(4);
    chk(drv, 16'h0003);
    chk(r2, 16'h00F0);
  endtask
  // parallel inputs OR onto channels 5 to 8
  task automatic t_par();
    par = 4'hA;
    cyc(8);
    chk(drv, 16'h00A3);
    par = 4'h0;
    cyc(8);
  endtask
  // glitch ignored, persistent over-current latches driver 1 off
  task automatic t_oc();
    par = 4'h5;
    oc = 8'h01;
    cyc(4);
    oc = 8'h00;
    cyc(8);
    chk(drv, 16'h0053);
    oc = 8'h01;
    cyc(20);
    oc = 8'h00;
    par = 4'h0;
    cyc(8);
    chk(drv, 16'h0002);
    frm(16'h0003, r);
    chk(r, 16'h0A02);
    chk(drv, 16'h0002);
    frm(16'h0002, r);
    frm(16'h0003, r);
    chk(r, 16'h0000);
    chk(drv, 16'h0003);
  endtask
  // pair shutdown, clear only when cool and pair disabled
  task automatic t_ts();
    ts = 4'h1;
    cyc(20);
    chk(drv, 16'h0000);
    frm(16'h0000, r);
    ts = 4'h0;
    cyc(20);
    frm(16'h0003, r);
    chk(r, 16'h0006);
    chk(drv, 16'h0000);
    frm(16'h0000, r);
    frm(16'h0003, r);
    chk(drv, 16'h0003);
    par = 4'h1;
    ts = 4'h4;
    cyc(20);
    ts = 4'h0;
    par = 4'h0;
    cyc(20);
    frm(16'h0003, r);
    chk(r, 16'h0260);
    frm(16'h0003, r);
    chk(r, 16'h0000);
  endtask
  // warning on miso at select fall with no clock, outputs stay
  task automatic t_tw();
    tw = 4'h2;
    cyc(20);
    chk(drv, 16'h0003);
    u_host.start();
    chk({15'h0000, miso}, 16'h0001);
    chk({15'h0000, miso_oe}, 16'h0001);
    u_host.word(16'h0003, 1'b0, r);
    u_host.stop();
    exp_fv++;
    chk(r, 16'h0001);
    tw = 4'h0;
    cyc(20);
  endtask
  // open load on off driver only, then load supply fault and recovery
  task automatic t_vs();
    frm(16'h0401, r);
    ol = 8'h05;
    cyc(20);
    frm(16'h0401, r);
    chk(r, 16'h0008);
    vs_ok = 1'b0;
    cyc(20);
    chk(drv, 16'h0000);
    frm(16'h0403, r);
    chk(r, 16'h8000);
    ol = 8'h00;
    vs_ok = 1'b1;
    cyc(20);
    chk(drv, 16'h0403);
    frm(16'h0403, r);
    chk(r, 16'h8000);
    frm(16'h0403, r);
    chk(r, 16'h0000);
  endtask
  // enable cycle clears a latch, logic supply loss clears the command
  task automatic t_en();
    oc = 8'h01;
    cyc(20);
    oc = 8'h00;
    en = 1'b0;
    cyc(6);
    chk(drv, 16'h0000);
    chk({15'h0000, stby}, 16'h0001);
    en = 1'b1;
    cyc(8);
    frm(16'h0001, r);
    chk(r, 16'h0000);
    chk(drv, 16'h0001);
    vcc_ok = 1'b0;
    cyc(6);
    chk(drv, 16'h0000);
    vcc_ok = 1'b1;
    cyc(8);
    chk(drv, 16'h0000);
    chk({15'h0000, miso_oe}, 16'h0000);
  endtask
  // main sequence
  initial
  begin
    cyc(16);
    chk(drv, 16'h0000);
    chk({15'h0000, stby}, 16'h0001);
    rst = 1'b0;
    cyc(8);
    t_frame();
    t_par();
    t_oc();
    t_ts();
    t_tw();
    t_vs();
    t_en();
    chk(16'(n_fv), 16'(exp_fv));
    summarize();
  end
  // hang guard, well past the expected run
  initial
  begin
    #100000;
    n_fail++;
    summarize();
  end
endmodule // odf_core_tb_top
